// [bench/gpb_board_model.sv]
// Board model: pin levels and the two sample strobes
`timescale 1ns/1ps
`default_nettype none

module gpb_board_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [49:0] pinOut,
    input wire logic [49:0] pinOe,
    input wire logic [49:0] pinDrive,
    output logic [49:0] pinIn,
    output logic pciSampleTick,
    output logic rtcSampleTick
);
    localparam logic [49:0] OD = 50'h1 << 49;
    localparam logic [49:0] NC = gpb_pkg::PINS_UNIMPL;
    logic [3:0] div_reg;
    logic [49:0] noise_reg;

    // ******************************************************
    // Strobes: awake sample every 4 cycles, sleep every 16
    // ******************************************************
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn)
            {div_reg, pciSampleTick, rtcSampleTick, noise_reg} <= '0;
        else
            {div_reg, pciSampleTick, rtcSampleTick, noise_reg} <= {div_reg + 4'h1,
                div_reg[1:0] == 2'h3, div_reg == 4'hf, ~noise_reg};

    // ******************************************************
    // Pad levels
    // ******************************************************
    // Absent pads float, so they toggle instead of holding a value
    assign pinIn = (pinOe & pinOut & ~OD) | (~pinOe & ~NC & ~OD & pinDrive)
        | (~pinOe & NC & noise_reg)
        | (~pinOe & OD);
endmodule : gpb_board_model

`default_nettype wire

// [bench/gpb_pin_bank_chk.sv]
// Port assertions of the pin bank
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_bank_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [49:0] pinOut,
    input wire logic [49:0] pinOe,
    input wire logic [49:0] altIn,
    input wire logic smiEvent,
    input wire logic sciEvent
);
    // Pin 49 drive follows its level, so it is left out
    localparam logic [49:0] FIX = gpb_pkg::PINS_OUT_ONLY & ~(50'h1 << 49);
    localparam logic [49:0] NC = gpb_pkg::PINS_UNIMPL;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer held too long");
    property p_nc_drive;
        ((pinOe | pinOut) & NC) == 50'h0;
    endproperty
    a_nc_drive: assert property (p_nc_drive) else $error("absent pin driven");
    property p_nc_alt;
        (altIn & NC) == 50'h0;
    endproperty
    a_nc_alt: assert property (p_nc_alt) else $error("absent pin alt");
    property p_od_low;
        pinOut[49] == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("pin 49 drives high");
    property p_out_on;
        $past(rstn) |-> (pinOe & FIX) == FIX;
    endproperty
    a_out_on: assert property (p_out_on) else $error("output released");
    property p_in_off;
        (pinOe & gpb_pkg::PINS_IN_ONLY) == 50'h0;
    endproperty
    a_in_off: assert property (p_in_off) else $error("input driven");
    property p_evt_hold;
        $fell(smiEvent) || $fell(sciEvent) |-> $past(avs_write, 2);
    endproperty
    a_evt_hold: assert property (p_evt_hold) else $error("event dropped alone");
endmodule : gpb_pin_bank_chk

bind gpb_pin_bank gpb_pin_bank_chk i_gpb_pin_bank_chk (.core_clk(core_clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .pinOut(pinOut), .pinOe(pinOe), .altIn(altIn), .smiEvent(smiEvent),
    .sciEvent(sciEvent));

`default_nettype wire

// [bench/testbench.sv]
// Scenario bench of the general-purpose pin bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end

module testbench;
    // Short blink half period keeps the run brief
    localparam int HALF = 4;
    logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, sleepState;
    logic pciSampleTick, rtcSampleTick, smiEvent, sciEvent;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [49:0] pinIn, pinOut, pinOe, altOut, altIn, pinDrive;
    int failures = 0;
    int checked = 0;
    int n;

    gpb_pin_bank #(.BLINK_HALF_CYCLES(HALF)) i_gpb_pin_bank (.core_clk(core_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .altOut(altOut), .altIn(altIn), .pciSampleTick(pciSampleTick),
        .rtcSampleTick(rtcSampleTick), .sleepState(sleepState), .smiEvent(smiEvent),
        .sciEvent(sciEvent));
    gpb_board_model i_gpb_board_model (.core_clk(core_clk), .rstn(rstn), .pinOut(pinOut),
        .pinOe(pinOe), .pinDrive(pinDrive), .pinIn(pinIn), .pciSampleTick(pciSampleTick),
        .rtcSampleTick(rtcSampleTick));

    // ******************************************************
    // Helpers
    // ******************************************************
    task automatic wt(input int k);
        repeat (k) @(posedge core_clk);
    endtask : wt

    task automatic tk(input int k, input logic rtc);
        repeat (k) @(posedge core_clk iff (rtc ? rtcSampleTick : pciSampleTick));
    endtask : tk

    // Extra edge at the end keeps two requests from sharing a time step
    // Only the watchdog ends a wait for the answer
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        `CHK(nm, e, q & m)
    endtask : rd

    task automatic toggleGap(input int b, output int k);
        logic v;
        v = pinOut[b];
        k = 0;
        while (pinOut[b] === v && k < 40)
        begin
            @(posedge core_clk);
            k++;
        end
    endtask : toggleGap

    // ******************************************************
    // Scenarios
    // ******************************************************
    task automatic t_reset;
        rd(8'h00, 32'hffbf_ffff, 32'hffbf_ffff, "use lo");
        rd(8'h04, 32'h1b00_0000, 32'h1b00_0000, "dir lo");
        rd(8'h18, 32'hffff_ffff, 32'h0004_0000, "blink");
        rd(8'h24, 32'hffff_ffff, 32'h0, "route");
        wr(8'h28, 32'hffff_ffff);
        rd(8'h28, 32'hffff_ffff, 32'h0, "unmapped");
        `CHK("oe", gpb_pkg::PINS_OUT_ONLY, pinOe)
        $display("test reset done");
    endtask : t_reset

    task automatic t_blink;
        toggleGap(18, n);
        toggleGap(18, n);
        `CHK("pin18 gap", HALF, n)
        wr(8'h18, 32'h000c_0000);
        toggleGap(19, n);
        toggleGap(19, n);
        `CHK("pin19 gap", HALF, n)
        wr(8'h18, 32'h0);
        wt(2);
        toggleGap(18, n);
        `CHK("pin18 off", 40, n)
        $display("test blink done");
    endtask : t_blink

    task automatic t_pins;
        wr(8'h04, 32'hfeff_ffff);
        wr(8'h08, 32'h01fc_0000);
        pinDrive[32] <= 1'b1;
        wr(8'h14, 32'h0002_0000);
        tk(3, 1'b0);
        `CHK("out 24..18", 7'h6f, pinOut[24:18])
        `CHK("oe 24", 1'b1, pinOe[24])
        `CHK("oe 49 off", 1'b0, pinOe[49])
        rd(8'h08, 32'h0040_0000, 32'h0, "level 22");
        rd(8'h14, 32'h0000_0001, 32'h1, "pin32 in");
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'hffff_ffff);
        `CHK("oe 49 on", 1'b1, pinOe[49])
        $display("test pins done");
    endtask : t_pins

    task automatic t_alt;
        altOut <= 50'h1_0000_0003_0000;
        wr(8'h00, 32'hfbfc_ffff);
        wr(8'h0c, 32'h0002_ffff);
        tk(3, 1'b0);
        `CHK("pin48 alt", 1'b1, pinOut[48])
        `CHK("pin17/16 alt", 2'h3, pinOut[17:16])
        `CHK("pin26 alt in", 1'b0, altIn[26])
        wr(8'h00, 32'hffff_ffff);
        wr(8'h0c, 32'h0003_ffff);
        wt(2);
        `CHK("pin26 plain", 1'b1, altIn[26])
        `CHK("pin17/16 plain", 2'h0, pinOut[17:16])
        $display("test alt done");
    endtask : t_alt

    task automatic t_sticky;
        wr(8'h24, 32'h0010_0018);
        rd(8'h24, 32'hffff_ffff, 32'h0010_0018, "route rw");
        tk(1, 1'b0);
        pinDrive[3] <= 1'b1;
        tk(1, 1'b0);
        pinDrive[3] <= 1'b0;
        tk(2, 1'b0);
        rd(8'h1c, 32'h0000_ffff, 32'h0, "one sample");
        pinDrive[3] <= 1'b1;
        tk(3, 1'b0);
        pinDrive[3] <= 1'b0;
        wt(3);
        `CHK("smi", 2'h2, {smiEvent, sciEvent})
        rd(8'h1c, 32'h0000_ffff, 32'h8, "sticky 3");
        wr(8'h1c, 32'h8);
        wt(2);
        `CHK("smi clr", 1'b0, smiEvent)
        pinDrive[4] <= 1'b1;
        tk(3, 1'b0);
        pinDrive[4] <= 1'b0;
        wt(3);
        `CHK("sci", 2'h1, {smiEvent, sciEvent})
        wr(8'h1c, 32'h10);
        rd(8'h1c, 32'h0000_ffff, 32'h0, "sticky clr");
        `CHK("sci clr", 1'b0, sciEvent)
        $display("test sticky done");
    endtask : t_sticky

    task automatic t_sleep;
        sleepState <= 1'b1;
        tk(1, 1'b1);
        pinDrive[8] <= 1'b1;
        wt(8);
        pinDrive[8] <= 1'b0;
        tk(2, 1'b1);
        rd(8'h1c, 32'h0000_ffff, 32'h0, "sleep fast");
        pinDrive[8] <= 1'b1;
        tk(3, 1'b1);
        pinDrive[8] <= 1'b0;
        wt(3);
        rd(8'h1c, 32'h0000_ffff, 32'h100, "sleep slow");
        sleepState <= 1'b0;
        $display("test sleep done");
    endtask : t_sleep

    task automatic tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Tests need a few hundred cycles; allow fifty thousand
    initial
    begin
        #5_000_000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {rstn, avs_read, avs_write, sleepState} = 4'h0;
        {avs_address, avs_writedata} = 40'h0;
        {altOut, pinDrive} = 100'h0;
        wt(6);
        rstn <= 1'b1;
        wt(2);
        t_reset();
        t_blink();
        t_pins();
        t_alt();
        t_sticky();
        t_sleep();
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire

// [verilog/gpb_pin_bank.sv]
// General-purpose pin bank with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_bank #(
    parameter int BLINK_HALF_CYCLES = gpb_pkg::BLINK_HALF_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [49:0] pinIn,
    output logic [49:0] pinOut,
    output logic [49:0] pinOe,
    input wire logic [49:0] altOut,
    output logic [49:0] altIn,
    input wire logic pciSampleTick,
    input wire logic rtcSampleTick,
    input wire logic sleepState,
    output logic smiEvent,
    output logic sciEvent
);

    // ******************************************************
    // State
    // ******************************************************
    gpb_pkg::gpb_bus_state_t busState_reg;
    logic waitreq_reg;
    logic [31:0] readdata_reg;
    logic [49:0] use_reg;
    logic [49:0] dir_reg;
    logic [49:0] level_reg;
    logic [49:0] samp_reg;
    logic [49:0] sampPrev_reg;
    logic [49:0] sticky_reg;
    logic [49:0] sticky_next;
    logic [31:0] blink_reg;
    logic [31:0] route_reg;
    logic [31:0] blinkCnt_reg;
    logic blinkPhase_reg;
    logic [49:0] pinOut_reg;
    logic [49:0] pinOe_reg;
    logic [49:0] altIn_reg;
    logic smi_reg;
    logic sci_reg;

    logic accept;
    logic wrAccept;
    logic sampleTick;
    logic [31:0] readValue;
    logic [49:0] isInput;
    logic [49:0] isOutput;
    logic [49:0] pinState;
    logic [49:0] outValue;
    logic [49:0] pinOut_next;
    logic [49:0] pinOe_next;
    logic [15:0] routeEn;
    logic [15:0] routeSci;

    // ******************************************************
    // Helpers
    // ******************************************************
    // Byte-lane merge of a write into the low or high word of a pin vector
    function automatic logic [49:0] merge50(
        input logic [49:0] oldv,
        input logic hi,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] m;
        logic [49:0] mask;
        logic [49:0] data;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        mask = hi ? {m[17:0], 32'h0000_0000} : {18'h0_0000, m};
        data = hi ? {wd[17:0], 32'h0000_0000} : {18'h0_0000, wd};
        merge50 = (oldv & ~mask) | (data & mask);
    endfunction : merge50

    function automatic logic [31:0] merge32(
        input logic [31:0] oldv,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge32 = (oldv & ~m) | (wd & m);
    endfunction : merge32

    // ******************************************************
    // Avalon-MM slave: one wait cycle, then answer
    // ******************************************************
    assign accept = (busState_reg == gpb_pkg::BUS_ACK) && (avs_read || avs_write);
    assign wrAccept = accept && avs_write;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busState_reg <= gpb_pkg::BUS_IDLE;
            waitreq_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end
        else
        begin
            case (busState_reg)
                gpb_pkg::BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        busState_reg <= gpb_pkg::BUS_ACK;
                        waitreq_reg <= 1'b0;
                        readdata_reg <= avs_read ? readValue : 32'h0000_0000;
                    end
                end
                gpb_pkg::BUS_ACK:
                begin
                    busState_reg <= gpb_pkg::BUS_IDLE;
                    waitreq_reg <= 1'b1;
                end
                default:
                begin
                    busState_reg <= gpb_pkg::BUS_IDLE;
                    waitreq_reg <= 1'b1;
                end
            endcase
        end
    end

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata = readdata_reg;

    // ******************************************************
    // Pin classes
    // ******************************************************
    // Unimplemented pins are in neither class, so they never drive or sample
    assign isInput = gpb_pkg::PINS_IN_ONLY | (gpb_pkg::PINS_BIDIR & dir_reg);
    assign isOutput = gpb_pkg::PINS_OUT_ONLY | (gpb_pkg::PINS_BIDIR & ~dir_reg);
    assign pinState = ((isOutput & level_reg) | (isInput & samp_reg))
        & ~gpb_pkg::PINS_UNIMPL;

    always_comb
    begin
        case (avs_address)
            gpb_pkg::OFS_USE_LO: readValue = use_reg[31:0];
            gpb_pkg::OFS_USE_HI: readValue = {14'h0000, use_reg[49:32]};
            gpb_pkg::OFS_DIR_LO: readValue = dir_reg[31:0];
            gpb_pkg::OFS_DIR_HI: readValue = {14'h0000, dir_reg[49:32]};
            gpb_pkg::OFS_LEVEL_LO: readValue = pinState[31:0];
            gpb_pkg::OFS_LEVEL_HI: readValue = {14'h0000, pinState[49:32]};
            gpb_pkg::OFS_BLINK: readValue = blink_reg;
            gpb_pkg::OFS_STICKY_LO: readValue = sticky_reg[31:0];
            gpb_pkg::OFS_STICKY_HI: readValue = {14'h0000, sticky_reg[49:32]};
            gpb_pkg::OFS_ROUTE: readValue = route_reg;
            default: readValue = 32'h0000_0000;
        endcase
    end

    // ******************************************************
    // Software control registers
    // ******************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            use_reg <= gpb_pkg::RST_USE;
            dir_reg <= gpb_pkg::RST_DIR;
            level_reg <= gpb_pkg::RST_LEVEL;
            blink_reg <= gpb_pkg::RST_BLINK;
            route_reg <= gpb_pkg::RST_ROUTE;
        end
        else if (wrAccept)
        begin
            case (avs_address)
                gpb_pkg::OFS_USE_LO:
                    use_reg <= merge50(use_reg, 1'b0, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_USE_HI:
                    use_reg <= merge50(use_reg, 1'b1, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_DIR_LO:
                    dir_reg <= merge50(dir_reg, 1'b0, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_DIR_HI:
                    dir_reg <= merge50(dir_reg, 1'b1, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_LEVEL_LO:
                    level_reg <= merge50(level_reg, 1'b0, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_LEVEL_HI:
                    level_reg <= merge50(level_reg, 1'b1, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_BLINK:
                    blink_reg <= merge32(blink_reg, avs_writedata, avs_byteenable);
                gpb_pkg::OFS_ROUTE:
                    route_reg <= merge32(route_reg, avs_writedata, avs_byteenable);
                default:
                begin
                end
            endcase
        end
    end

    // ******************************************************
    // Input sampling and sticky status
    // ******************************************************
    // Sampling strobe follows the power state
    assign sampleTick = sleepState ? rtcSampleTick : pciSampleTick;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            samp_reg <= 50'h0_0000_0000_0000;
            sampPrev_reg <= 50'h0_0000_0000_0000;
        end
        else if (sampleTick)
        begin
            samp_reg <= pinIn & ~gpb_pkg::PINS_UNIMPL;
            sampPrev_reg <= samp_reg;
        end
    end

    // Set beats a same-cycle write-one clear, so no event is lost
    always_comb
    begin
        sticky_next = sticky_reg;
        if (wrAccept && (avs_address == gpb_pkg::OFS_STICKY_LO))
        begin
            sticky_next = sticky_reg
                & ~merge50(50'h0_0000_0000_0000, 1'b0, avs_writedata, avs_byteenable);
        end
        if (wrAccept && (avs_address == gpb_pkg::OFS_STICKY_HI))
        begin
            sticky_next = sticky_reg
                & ~merge50(50'h0_0000_0000_0000, 1'b1, avs_writedata, avs_byteenable);
        end
        sticky_next = sticky_next | (samp_reg & sampPrev_reg & isInput);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sticky_reg <= 50'h0_0000_0000_0000;
        end
        else
        begin
            sticky_reg <= sticky_next;
        end
    end

    // ******************************************************
    // Interrupt routing of inputs 15..0
    // ******************************************************
    // One select bit per input makes routing to both impossible
    assign routeEn = route_reg[gpb_pkg::ROUTE_EN_LSB +: 16];
    assign routeSci = route_reg[gpb_pkg::ROUTE_SEL_LSB +: 16];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            smi_reg <= 1'b0;
            sci_reg <= 1'b0;
        end
        else
        begin
            smi_reg <= |(sticky_reg[15:0] & routeEn & ~routeSci);
            sci_reg <= |(sticky_reg[15:0] & routeEn & routeSci);
        end
    end

    assign smiEvent = smi_reg;
    assign sciEvent = sci_reg;

    // ******************************************************
    // Blink divider
    // ******************************************************
    // Slow rate is a trade for a wide counter; shorten the parameter in simulation
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blinkCnt_reg <= 32'h0000_0000;
            blinkPhase_reg <= 1'b0;
        end
        else if (blinkCnt_reg >= 32'(BLINK_HALF_CYCLES - 1))
        begin
            blinkCnt_reg <= 32'h0000_0000;
            blinkPhase_reg <= ~blinkPhase_reg;
        end
        else
        begin
            blinkCnt_reg <= blinkCnt_reg + 32'h0000_0001;
        end
    end

    // ******************************************************
    // Pin drive
    // ******************************************************
    always_comb
    begin
        outValue = level_reg;
        if (blink_reg[gpb_pkg::BLINK_PIN_A])
        begin
            outValue[gpb_pkg::BLINK_PIN_A] = blinkPhase_reg;
        end
        if (blink_reg[gpb_pkg::BLINK_PIN_B])
        begin
            outValue[gpb_pkg::BLINK_PIN_B] = blinkPhase_reg;
        end
        // Cleared select bit hands alternate-capable pins to their function
        outValue = (outValue & (use_reg | ~gpb_pkg::PINS_ALT))
            | (altOut & ~use_reg & gpb_pkg::PINS_ALT);
        pinOut_next = outValue & isOutput;
        pinOe_next = isOutput;
        // Open-drain pin only ever pulls low
        pinOut_next[gpb_pkg::OD_PIN] = 1'b0;
        pinOe_next[gpb_pkg::OD_PIN] = ~outValue[gpb_pkg::OD_PIN];
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pinOut_reg <= 50'h0_0000_0000_0000;
            pinOe_reg <= 50'h0_0000_0000_0000;
            altIn_reg <= 50'h0_0000_0000_0000;
        end
        else
        begin
            pinOut_reg <= pinOut_next;
            pinOe_reg <= pinOe_next;
            // Alternate inputs idle high when their pin stays general purpose
            altIn_reg <= gpb_pkg::PINS_ALT & gpb_pkg::PINS_IN_ONLY
                & (samp_reg | use_reg);
        end
    end

    assign pinOut = pinOut_reg;
    assign pinOe = pinOe_reg;
    assign altIn = altIn_reg;

endmodule : gpb_pin_bank

`default_nettype wire

// [verilog/gpb_pkg.sv]
// Constants, register map and pin masks of the general-purpose pin bank

`default_nettype none

package gpb_pkg;

    // ******************************************************
    // Register map, byte addresses
    // ******************************************************
    localparam logic [7:0] OFS_USE_LO = 8'h00;
    localparam logic [7:0] OFS_DIR_LO = 8'h04;
    localparam logic [7:0] OFS_LEVEL_LO = 8'h08;
    localparam logic [7:0] OFS_USE_HI = 8'h0c;
    localparam logic [7:0] OFS_DIR_HI = 8'h10;
    localparam logic [7:0] OFS_LEVEL_HI = 8'h14;
    localparam logic [7:0] OFS_BLINK = 8'h18;
    localparam logic [7:0] OFS_STICKY_LO = 8'h1c;
    localparam logic [7:0] OFS_STICKY_HI = 8'h20;
    localparam logic [7:0] OFS_ROUTE = 8'h24;

    // ******************************************************
    // Pin classes, bit n is pin n
    // ******************************************************
    localparam logic [49:0] PINS_UNIMPL = 50'h0_fcf8_0040_0000;
    localparam logic [49:0] PINS_OUT_ONLY = 50'h3_0000_00bf_0000;
    localparam logic [49:0] PINS_IN_ONLY = 50'h0_0300_e400_ffff;
    localparam logic [49:0] PINS_BIDIR = 50'h0_0007_1b00_0000;
    localparam logic [49:0] PINS_ALT = 50'h3_0300_e403_ce3f;

    // ******************************************************
    // Field positions and reset values
    // ******************************************************
    localparam int OD_PIN = 49;
    localparam int BLINK_PIN_A = 18;
    localparam int BLINK_PIN_B = 19;
    localparam int ROUTE_EN_LSB = 0;
    localparam int ROUTE_SEL_LSB = 16;
    localparam logic [49:0] RST_USE = 50'h3_ffff_ffff_ffff;
    localparam logic [49:0] RST_DIR = 50'h3_ffff_ffff_ffff;
    localparam logic [49:0] RST_LEVEL = 50'h0_0000_0000_0000;
    localparam logic [31:0] RST_BLINK = 32'h0004_0000;
    localparam logic [31:0] RST_ROUTE = 32'h0000_0000;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);

    typedef enum logic {BUS_IDLE, BUS_ACK} gpb_bus_state_t;

endpackage : gpb_pkg

`default_nettype wire
